// ### common/sit_pkg.sv
/*
 * Shared constants and types for the sixteen-bit interval timer: register
 * offsets, control field layout, reset values and crossing delay.
 * Assumes a 32-bit classic Wishbone slave port with registers in the low 16 bits.
 */
package sit_pkg;
    // byte offsets of the register words
    localparam logic [3:0]  ADR_CONTROL        = 4'h0;
    localparam logic [3:0]  ADR_COUNT          = 4'h4;
    localparam logic [3:0]  ADR_PERIOD         = 4'h8;
    localparam logic [3:0]  ADR_STATUS         = 4'hC;
    // control field positions
    localparam int          BIT_RUN            = 15;
    localparam int          BIT_IDLE_HALT      = 13;
    localparam int          BIT_WRITE_BLOCK    = 12;
    localparam int          BIT_COUNT_PEND     = 11;
    localparam int          BIT_PERIOD_PEND    = 10;
    localparam int          BIT_ECLK_HI        = 9;
    localparam int          BIT_ECLK_LO        = 8;
    localparam int          BIT_GATED          = 7;
    localparam int          BIT_PSC_HI         = 5;
    localparam int          BIT_PSC_LO         = 4;
    localparam int          BIT_EXT_SYNC       = 2;
    localparam int          BIT_SOURCE         = 1;
    localparam int          BIT_EVENT          = 0;
    // reset values
    localparam logic [15:0] CONTROL_RST        = 16'h0000;
    localparam logic [15:0] COUNT_RST          = 16'h0000;
    localparam logic [15:0] PERIOD_RST         = 16'hFFFF;
    // extended clock choices
    localparam logic [1:0]  ECLK_PIN           = 2'h0;
    localparam logic [1:0]  ECLK_PERIPH        = 2'h1;
    localparam logic [1:0]  ECLK_OSC           = 2'h2;
    localparam logic [1:0]  ECLK_FRC           = 2'h3;
    // prescaler terminal counts (ratio minus one)
    localparam logic [7:0]  PSC_LAST_1         = 8'h00;
    localparam logic [7:0]  PSC_LAST_8         = 8'h07;
    localparam logic [7:0]  PSC_LAST_64        = 8'h3F;
    localparam logic [7:0]  PSC_LAST_256       = 8'hFF;
    // crossing timer load; a posted write spends four cycles crossing into the counting domain
    localparam logic [1:0]  ASYNC_XFER_LAST    = 2'h3;

    typedef struct packed {
        logic       run_control;
        logic       idle_halt;
        logic       async_write_block;
        logic [1:0] extended_clock_choice;
        logic       gated_accumulate;
        logic [1:0] prescale_select;
        logic       ext_sync_select;
        logic       source_select;
    } sit_ctrl_t;

    typedef struct packed {
        logic       sleep;
        logic       idle;
    } sit_power_t;
endpackage

// ### src/sit_timer.sv
/*
 * Sixteen-bit interval timer/counter with prescaler, gating, sync and
 * async counting paths and posted writes, behind a classic Wishbone slave.
 * Assumes clock inputs from pins are slow against i_clk and are sampled
 * here; a faster oscillator than i_clk would lose edges.
 */
`timescale 1ns/1ps
module sit_timer (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [3:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // clock sources and gate
    input  wire logic        i_ext_count_pin,
    input  wire logic        i_osc_clock,
    input  wire logic        i_fast_rc_clock,
    // power state
    input  wire sit_pkg::sit_power_t i_power,
    // timer state
    output logic      [15:0] o_count_value,
    output logic             o_event
);
    sit_pkg::sit_ctrl_t ctrl_reg;
    logic [15:0]        count_reg;
    logic [15:0]        period_reg;
    logic               event_reg;
    logic               ack_reg;
    logic [31:0]        rdat_reg;
    logic [2:0]         sync_reg [3];
    logic [2:0]         edge_w;
    logic [2:0]         level_w;
    logic [7:0]         psc_cnt_reg;
    logic [7:0]         psc_last_w;
    logic               psc_tick_w;
    logic               psc_sync_reg;
    logic               src_tick_w;
    logic               inc_w;
    logic               async_mode_w;
    logic               gated_w;
    logic               gate_fall_w;
    logic               stalled_w;
    logic               req_w;
    logic               wr_w;
    logic               cw_ok_w;
    logic               pw_ok_w;
    logic               cw_pend_reg;
    logic               pw_pend_reg;
    logic [1:0]         cw_tmr_reg;
    logic [1:0]         pw_tmr_reg;
    logic [15:0]        cw_data_reg;
    logic [15:0]        pw_data_reg;
    logic               cw_apply_w;
    logic               pw_apply_w;
    logic [15:0]        ctrl_rd_w;

    // three-stage samplers: pin, oscillator, fast rc; a rise counts when stage 2 is high and stage 3 still low
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            logic pin_w;
            assign pin_w = (g == 0) ? i_ext_count_pin : ((g == 1) ? i_osc_clock : i_fast_rc_clock);
            always_ff @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    sync_reg[g] <= 3'h0;
                end else begin
                    sync_reg[g] <= {sync_reg[g][1:0], pin_w};
                end
            end
            assign edge_w[g]  = sync_reg[g][1] & ~sync_reg[g][2];
            assign level_w[g] = sync_reg[g][2];
        end
    endgenerate

    assign async_mode_w = ctrl_reg.source_select & ~ctrl_reg.ext_sync_select;
    assign gated_w      = ~ctrl_reg.source_select & ctrl_reg.gated_accumulate;
    assign gate_fall_w  = gated_w & ctrl_reg.run_control
                        & ~sync_reg[0][1] & sync_reg[0][2];
    // sleep stops the system clock path; only the async counter survives it
    assign stalled_w = ~ctrl_reg.run_control
                     | (i_power.idle & ctrl_reg.idle_halt)
                     | (i_power.sleep & ~async_mode_w);

    always_comb begin
        src_tick_w = 1'b0;
        if (!ctrl_reg.source_select) begin
            src_tick_w = gated_w ? level_w[0] : 1'b1;
        end else begin
            case (ctrl_reg.extended_clock_choice)
                sit_pkg::ECLK_PIN:    src_tick_w = edge_w[0];
                sit_pkg::ECLK_PERIPH: src_tick_w = 1'b1;
                sit_pkg::ECLK_OSC:    src_tick_w = edge_w[1];
                sit_pkg::ECLK_FRC:    src_tick_w = edge_w[2];
                default:              src_tick_w = 1'b0;
            endcase
        end
    end

    always_comb begin
        case (ctrl_reg.prescale_select)
            2'h0:    psc_last_w = sit_pkg::PSC_LAST_1;
            2'h1:    psc_last_w = sit_pkg::PSC_LAST_8;
            2'h2:    psc_last_w = sit_pkg::PSC_LAST_64;
            default: psc_last_w = sit_pkg::PSC_LAST_256;
        endcase
    end

    assign psc_tick_w = ~stalled_w & src_tick_w & (psc_cnt_reg == psc_last_w);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            psc_cnt_reg <= 8'h00;
        end else if (!ctrl_reg.run_control) begin
            psc_cnt_reg <= 8'h00;
        end else if (!stalled_w && src_tick_w) begin
            psc_cnt_reg <= (psc_cnt_reg == psc_last_w) ? 8'h00 : psc_cnt_reg + 8'h01;
        end
    end

    // extra stage on the prescaler output costs one cycle of latency in sync mode
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            psc_sync_reg <= 1'b0;
        end else begin
            psc_sync_reg <= psc_tick_w & ctrl_reg.source_select & ctrl_reg.ext_sync_select;
        end
    end

    // sync counter uses the delayed tick, all other modes the direct one
    assign inc_w = (ctrl_reg.source_select && ctrl_reg.ext_sync_select) ?
                   (psc_sync_reg & ~stalled_w) : psc_tick_w;

    // wishbone decode
    assign req_w   = i_wb_cyc & i_wb_stb & ~ack_reg;
    assign wr_w    = req_w & i_wb_we & i_wb_sel[0] & i_wb_sel[1];
    assign cw_ok_w = wr_w && (i_wb_adr == sit_pkg::ADR_COUNT)
                   && !(ctrl_reg.run_control && ctrl_reg.source_select
                        && ctrl_reg.ext_sync_select)
                   && !(async_mode_w && ctrl_reg.async_write_block
                        && (cw_pend_reg || pw_pend_reg));
    assign pw_ok_w = wr_w && (i_wb_adr == sit_pkg::ADR_PERIOD)
                   && !(async_mode_w && ctrl_reg.async_write_block
                        && (cw_pend_reg || pw_pend_reg));

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_reg <= '0;
        end else if (wr_w && i_wb_adr == sit_pkg::ADR_CONTROL) begin
            ctrl_reg.run_control           <= i_wb_dat[sit_pkg::BIT_RUN];
            ctrl_reg.idle_halt             <= i_wb_dat[sit_pkg::BIT_IDLE_HALT];
            ctrl_reg.async_write_block     <= i_wb_dat[sit_pkg::BIT_WRITE_BLOCK];
            ctrl_reg.extended_clock_choice <= i_wb_dat[sit_pkg::BIT_ECLK_HI:sit_pkg::BIT_ECLK_LO];
            ctrl_reg.gated_accumulate      <= i_wb_dat[sit_pkg::BIT_GATED];
            ctrl_reg.prescale_select       <= i_wb_dat[sit_pkg::BIT_PSC_HI:sit_pkg::BIT_PSC_LO];
            ctrl_reg.ext_sync_select       <= i_wb_dat[sit_pkg::BIT_EXT_SYNC];
            ctrl_reg.source_select         <= i_wb_dat[sit_pkg::BIT_SOURCE];
        end
    end

    // posted writes: count and period write crossings
    assign cw_apply_w = cw_pend_reg & (cw_tmr_reg == 2'h0);
    assign pw_apply_w = pw_pend_reg & (pw_tmr_reg == 2'h0);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cw_pend_reg <= 1'b0;
            cw_tmr_reg  <= 2'h0;
            cw_data_reg <= sit_pkg::COUNT_RST;
        end else if (cw_ok_w && async_mode_w) begin
            cw_pend_reg <= 1'b1;
            cw_tmr_reg  <= sit_pkg::ASYNC_XFER_LAST;
            cw_data_reg <= i_wb_dat[15:0];
        end else if (cw_apply_w) begin
            cw_pend_reg <= 1'b0;
        end else if (cw_pend_reg) begin
            cw_tmr_reg  <= cw_tmr_reg - 2'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pw_pend_reg <= 1'b0;
            pw_tmr_reg  <= 2'h0;
            pw_data_reg <= sit_pkg::PERIOD_RST;
        end else if (pw_ok_w && async_mode_w) begin
            pw_pend_reg <= 1'b1;
            pw_tmr_reg  <= sit_pkg::ASYNC_XFER_LAST;
            pw_data_reg <= i_wb_dat[15:0];
        end else if (pw_apply_w) begin
            pw_pend_reg <= 1'b0;
        end else if (pw_pend_reg) begin
            pw_tmr_reg  <= pw_tmr_reg - 2'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            period_reg <= sit_pkg::PERIOD_RST;
        end else if (pw_ok_w && !async_mode_w) begin
            period_reg <= i_wb_dat[15:0];
        end else if (pw_apply_w) begin
            period_reg <= pw_data_reg;
        end
    end

    // a software load beats an increment in the same cycle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            count_reg <= sit_pkg::COUNT_RST;
        end else if (cw_ok_w && !async_mode_w) begin
            count_reg <= i_wb_dat[15:0];
        end else if (cw_apply_w) begin
            count_reg <= cw_data_reg;
        end else if (inc_w) begin
            count_reg <= (count_reg == period_reg) ? 16'h0000 : count_reg + 16'h1;
        end
    end
    // set wins over the write-one-to-clear
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            event_reg <= 1'b0;
        end else if ((inc_w && count_reg == period_reg && !gated_w) || gate_fall_w) begin
            event_reg <= 1'b1;
        end else if (wr_w && i_wb_adr == sit_pkg::ADR_STATUS && i_wb_dat[sit_pkg::BIT_EVENT]) begin
            event_reg <= 1'b0;
        end
    end

    always_comb begin
        ctrl_rd_w = 16'h0000;
        ctrl_rd_w[sit_pkg::BIT_RUN]         = ctrl_reg.run_control;
        ctrl_rd_w[sit_pkg::BIT_IDLE_HALT]   = ctrl_reg.idle_halt;
        ctrl_rd_w[sit_pkg::BIT_WRITE_BLOCK] = ctrl_reg.async_write_block;
        ctrl_rd_w[sit_pkg::BIT_COUNT_PEND]  = cw_pend_reg;
        ctrl_rd_w[sit_pkg::BIT_PERIOD_PEND] = pw_pend_reg;
        ctrl_rd_w[sit_pkg::BIT_ECLK_HI:sit_pkg::BIT_ECLK_LO] = ctrl_reg.extended_clock_choice;
        ctrl_rd_w[sit_pkg::BIT_GATED]       = ctrl_reg.gated_accumulate;
        ctrl_rd_w[sit_pkg::BIT_PSC_HI:sit_pkg::BIT_PSC_LO] = ctrl_reg.prescale_select;
        ctrl_rd_w[sit_pkg::BIT_EXT_SYNC]    = ctrl_reg.ext_sync_select;
        ctrl_rd_w[sit_pkg::BIT_SOURCE]      = ctrl_reg.source_select;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req_w;
            if (req_w) begin
                case (i_wb_adr)
                    sit_pkg::ADR_CONTROL: rdat_reg <= {16'h0000, ctrl_rd_w};
                    sit_pkg::ADR_COUNT:   rdat_reg <= {16'h0000, count_reg};
                    sit_pkg::ADR_PERIOD:  rdat_reg <= {16'h0000, period_reg};
                    sit_pkg::ADR_STATUS:  rdat_reg <= {31'h0000_0000, event_reg};
                    default:              rdat_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign o_wb_ack      = ack_reg;
    assign o_wb_dat      = rdat_reg;
    assign o_count_value = count_reg;
    assign o_event       = event_reg;
    a_ctrl_zero_bits :
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        req_w && i_wb_adr == sit_pkg::ADR_CONTROL |=> rdat_reg[14] == 1'b0 && rdat_reg[6] == 1'b0
        && rdat_reg[3] == 1'b0 && rdat_reg[0] == 1'b0)
    else $error("unimplemented control bit read nonzero");
    a_stop_holds :
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        !ctrl_reg.run_control && !cw_ok_w && !cw_apply_w |=> $stable(count_reg))
    else $error("count moved while stopped");
    a_period_wrap :
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        inc_w && count_reg == period_reg && !cw_ok_w && !cw_apply_w && !gated_w
        |=> count_reg == 16'h0000 && event_reg)
    else $error("period match did not wrap and flag");
    a_count_pending :
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        cw_ok_w && async_mode_w |=> cw_pend_reg [*4] ##1 !cw_pend_reg)
    else $error("count pending flag wrong length");
    a_period_pending :
    assert property (@(posedge i_clk) disable iff (!i_rstn) pw_ok_w && async_mode_w
        |=> pw_pend_reg [*4] ##1 (!pw_pend_reg && period_reg == $past(pw_data_reg)))
    else $error("period posted write wrong");
    a_write_blocked :
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        async_mode_w && ctrl_reg.async_write_block && cw_pend_reg |-> !cw_ok_w && !pw_ok_w)
    else $error("write accepted while blocked");
    a_sync_count_wr :
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        ctrl_reg.run_control && ctrl_reg.source_select && ctrl_reg.ext_sync_select |-> !cw_ok_w)
    else $error("count write taken in sync counter mode");
    a_idle_halt :
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_power.idle && ctrl_reg.idle_halt |-> !inc_w)
    else $error("counted during idle halt");
    // only back-to-back source ticks pin the previous prescaler value; sparse sources hold it
    a_psc_eight :
    assert property (@(posedge i_clk) disable iff (!i_rstn) psc_tick_w && $past(src_tick_w)
        && !$past(stalled_w) && ctrl_reg.prescale_select == 2'h1 |-> $past(psc_cnt_reg) == 8'h06)
    else $error("divide by eight tick misplaced");
    a_ack_drop :
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_wb_ack |=> !o_wb_ack)
    else $error("ack held two cycles");
    c_wrap : cover property (@(posedge i_clk) disable iff (!i_rstn)
        inc_w && count_reg == period_reg);
    c_gate_fall : cover property (@(posedge i_clk) disable iff (!i_rstn) gate_fall_w);
    c_async_done : cover property (@(posedge i_clk) disable iff (!i_rstn) cw_apply_w);
endmodule

// ### tb/sixteen_bit_interval_timer_tb.sv
/*
 * Self-checking bench for the interval timer: reset values, a table of
 * counting modes, then wrap, stop, power states, gating and posted writes by hand.
 * Assumes the one-cycle Wishbone answer and posted-write delay of the timer.
 */
`timescale 1ns/1ps
module sixteen_bit_interval_timer_tb;
    logic                i_clk;
    logic                i_rstn;
    logic                cyc;
    logic                stb;
    logic                we;
    logic [3:0]          adr;
    logic [31:0]         wdat;
    logic [31:0]         o_wb_dat;
    logic                o_wb_ack;
    logic                pin;
    logic [3:0]          div;
    sit_pkg::sit_power_t pwr;
    logic [15:0]         o_count_value;
    logic                o_event;
    logic [31:0]         rd;
    logic [15:0]         hold;
    int                  g;
    int                  errors;
    int                  compares;
    // mode rows: control word and cycles between increments
    logic [15:0] row_ctrl [10] = '{16'h8000, 16'h8010, 16'h8020, 16'h8030, 16'h8106,
                                   16'h8206, 16'h8306, 16'h8216, 16'h8202, 16'hFFCF};
    int          row_gap  [10] = '{1, 8, 64, 256, 1, 4, 8, 32, 4, 8};

    sit_timer DUT (
        .i_clk           (i_clk),
        .i_rstn          (i_rstn),
        .i_wb_cyc        (cyc),
        .i_wb_stb        (stb),
        .i_wb_we         (we),
        .i_wb_adr        (adr),
        .i_wb_sel        (4'hF),
        .i_wb_dat        (wdat),
        .o_wb_dat        (o_wb_dat),
        .o_wb_ack        (o_wb_ack),
        .i_ext_count_pin (pin),
        .i_osc_clock     (div[1]),
        .i_fast_rc_clock (div[2]),
        .i_power         (pwr),
        .o_count_value   (o_count_value),
        .o_event         (o_event)
    );

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    // alternate sources: osc at clk/4, fast rc at clk/8, slow enough to be sampled
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div <= 4'h0;
        end else begin
            div <= div + 4'h1;
        end
    end

    task automatic results;
        $display("comparisons %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic timeout;
        errors++;
        $display("[FAIL] wait expected answer seen none");
        results();
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one classic cycle; returns at the ack edge with the request released
    task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        do begin
            @(posedge i_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 50);
        rd = o_wb_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (o_wb_ack !== 1'b1) timeout();
    endtask

    // cycles between two successive count changes
    task automatic gap_of(output int n);
        logic [15:0] v;
        v = o_count_value;
        n = 0;
        while (o_count_value === v && n < 2000) begin
            @(posedge i_clk);
            n++;
        end
        v = o_count_value;
        n = 0;
        while (o_count_value === v && n < 2000) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 2000) timeout();
    endtask

    task automatic wait_cnt(input logic [15:0] v);
        int n;
        n = 0;
        while (o_count_value !== v && n < 2000) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 2000) timeout();
    endtask

    initial begin
        i_rstn = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        wdat = 32'h0000_0000;
        pin = 1'b0;
        pwr = '0;
        errors = 0;
        compares = 0;
        repeat (12) @(posedge i_clk);
        i_rstn <= 1'b1;
        wb(1'b0, sit_pkg::ADR_CONTROL, 16'h0000);
        chk("control reset", {16'h0000, sit_pkg::CONTROL_RST}, rd);
        wb(1'b0, sit_pkg::ADR_PERIOD, 16'h0000);
        chk("period reset", {16'h0000, sit_pkg::PERIOD_RST}, rd);
        chk("count reset", 32'h0000_0000, {16'h0000, o_count_value});
        wb(1'b1, sit_pkg::ADR_CONTROL, 16'hFFFF);
        wb(1'b0, sit_pkg::ADR_CONTROL, 16'h0000);
        chk("control all ones", 32'h0000_B3B6, rd);
        for (int i = 0; i < 10; i++) begin
            wb(1'b1, sit_pkg::ADR_CONTROL, 16'h0000);
            wb(1'b1, sit_pkg::ADR_COUNT, 16'h0000);
            wb(1'b1, sit_pkg::ADR_CONTROL, row_ctrl[i]);
            wb(1'b0, sit_pkg::ADR_CONTROL, 16'h0000);
            chk("control readback", {16'h0000, row_ctrl[i] & 16'hB3B6}, rd);
            gap_of(g);
            chk("tick gap", row_gap[i], g);
        end
        // wrap at period, then stop and clear the event
        wb(1'b1, sit_pkg::ADR_CONTROL, 16'h0000);
        wb(1'b1, sit_pkg::ADR_COUNT, 16'h0000);
        wb(1'b1, sit_pkg::ADR_PERIOD, 16'h0003);
        wb(1'b1, sit_pkg::ADR_STATUS, 16'h0001);
        wb(1'b1, sit_pkg::ADR_CONTROL, 16'h8000);
        wait_cnt(16'h0003);
        @(posedge i_clk);
        chk("count after period", 32'h0000_0000, {16'h0000, o_count_value});
        chk("event at wrap", 32'h0000_0001, {31'h0, o_event});
        wb(1'b1, sit_pkg::ADR_CONTROL, 16'h0000);
        wb(1'b1, sit_pkg::ADR_STATUS, 16'h0001);
        wb(1'b0, sit_pkg::ADR_STATUS, 16'h0000);
        chk("event cleared", 32'h0000_0000, rd);
        hold = o_count_value;
        repeat (20) @(posedge i_clk);
        chk("stopped count", {16'h0000, hold}, {16'h0000, o_count_value});
        // idle with and without the halt bit
        wb(1'b1, sit_pkg::ADR_PERIOD, 16'hFFFF);
        wb(1'b1, sit_pkg::ADR_CONTROL, 16'hA000);
        pwr.idle <= 1'b1;
        repeat (4) @(posedge i_clk);
        hold = o_count_value;
        repeat (20) @(posedge i_clk);
        chk("idle halted", {16'h0000, hold}, {16'h0000, o_count_value});
        wb(1'b1, sit_pkg::ADR_CONTROL, 16'h8000);
        gap_of(g);
        chk("idle running", 32'h0000_0001, g);
        pwr.idle <= 1'b0;
        // async pin counting while asleep, then a refused count write in sync mode
        wb(1'b1, sit_pkg::ADR_CONTROL, 16'h0000);
        wb(1'b1, sit_pkg::ADR_COUNT, 16'h0000);
        wb(1'b1, sit_pkg::ADR_CONTROL, 16'h8002);
        pwr.sleep <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            pin <= 1'b1;
            repeat (4) @(posedge i_clk);
            pin <= 1'b0;
            repeat (4) @(posedge i_clk);
        end
        repeat (10) @(posedge i_clk);
        chk("sleep pin count", 32'h0000_0005, {16'h0000, o_count_value});
        pwr.sleep <= 1'b0;
        wb(1'b1, sit_pkg::ADR_CONTROL, 16'h8006);
        wb(1'b1, sit_pkg::ADR_COUNT, 16'h0055);
        wb(1'b0, sit_pkg::ADR_COUNT, 16'h0000);
        chk("sync count write", 32'h0000_0005, rd);
        // gated accumulation over a ten-cycle gate
        wb(1'b1, sit_pkg::ADR_CONTROL, 16'h0000);
        wb(1'b1, sit_pkg::ADR_COUNT, 16'h0000);
        wb(1'b1, sit_pkg::ADR_STATUS, 16'h0001);
        wb(1'b1, sit_pkg::ADR_CONTROL, 16'h8080);
        repeat (10) @(posedge i_clk);
        chk("gate low count", 32'h0000_0000, {16'h0000, o_count_value});
        pin <= 1'b1;
        repeat (10) @(posedge i_clk);
        pin <= 1'b0;
        repeat (10) @(posedge i_clk);
        chk("gated count", 32'h0000_000A, {16'h0000, o_count_value});
        chk("gate fall event", 32'h0000_0001, {31'h0, o_event});
        // posted writes: flags first, then a blocked write, then back to back
        wb(1'b1, sit_pkg::ADR_CONTROL, 16'h1002);
        wb(1'b1, sit_pkg::ADR_COUNT, 16'h0010);
        wb(1'b0, sit_pkg::ADR_CONTROL, 16'h0000);
        chk("count pending", 32'h0000_0001, {31'h0, rd[11]});
        repeat (8) @(posedge i_clk);
        wb(1'b0, sit_pkg::ADR_COUNT, 16'h0000);
        chk("posted count", 32'h0000_0010, rd);
        wb(1'b0, sit_pkg::ADR_CONTROL, 16'h0000);
        chk("pending clear", 32'h0000_0000, {30'h0, rd[11:10]});
        wb(1'b1, sit_pkg::ADR_PERIOD, 16'h0020);
        wb(1'b0, sit_pkg::ADR_CONTROL, 16'h0000);
        chk("period pending", 32'h0000_0001, {31'h0, rd[10]});
        repeat (8) @(posedge i_clk);
        wb(1'b0, sit_pkg::ADR_PERIOD, 16'h0000);
        chk("posted period", 32'h0000_0020, rd);
        // period write lands three cycles into the count crossing, so it must be dropped
        wb(1'b1, sit_pkg::ADR_COUNT, 16'h0011);
        wb(1'b1, sit_pkg::ADR_PERIOD, 16'h0040);
        repeat (8) @(posedge i_clk);
        wb(1'b0, sit_pkg::ADR_PERIOD, 16'h0000);
        chk("blocked period", 32'h0000_0020, rd);
        wb(1'b1, sit_pkg::ADR_CONTROL, 16'h0002);
        wb(1'b1, sit_pkg::ADR_COUNT, 16'h0030);
        wb(1'b1, sit_pkg::ADR_PERIOD, 16'h0040);
        repeat (8) @(posedge i_clk);
        wb(1'b0, sit_pkg::ADR_PERIOD, 16'h0000);
        chk("back to back period", 32'h0000_0040, rd);
        wb(1'b0, sit_pkg::ADR_COUNT, 16'h0000);
        chk("back to back count", 32'h0000_0030, rd);
        results();
    end
endmodule
